//--- rtl/ssr_pkg.sv
// constants, register map and carrier types of the synchronous serial receiver
// Summary of operation
// - master receiver never drives the serial data pin
// - reception starts only when single or continuous receive enable is set
// - single receive: master makes exactly one character's worth of clock cycles
// - single receive enable clears itself after one complete character
// - continuous receive: master clocks without pause until the enable clears or an overrun sets
// - continuous enable cleared mid character stops clock, drops partial character
// - both enables set: single clears after first character, continuous goes on
// - data pin sampled at trailing clock edge into the receive shift register
// - complete character sets receive flag and moves into the two-entry fifo
// - receive data register shows low eight bits of oldest unread character
// - receive flag stays set while the fifo holds any unread character
// - slave takes clock from far end and never drives the clock pin
// - sender changes data on leading edge; one bit per clock cycle
// - third character with full fifo sets overrun, fifo left untouched
// - while overrun pends no character is accepted; stored ones stay readable
// - single-mode overrun cleared by data read; continuous by clearing continuous enable
// - clearing serial port enable resets the unit and the overrun
// - nine-bit mode shifts nine bits; ninth bit of oldest character is status
// - interrupt request when receive flag and all its enables are set
package ssr_pkg;
    localparam logic [3:0] SSR_ADDR_CTRL = 4'h0;
    localparam logic [3:0] SSR_ADDR_STATUS = 4'h4;
    localparam logic [3:0] SSR_ADDR_DATA = 4'h8;
    localparam logic [3:0] SSR_ADDR_BAUD = 4'hc;
    localparam int SSR_CTRL_W = 10;
    localparam logic [SSR_CTRL_W-1:0] SSR_CTRL_RST = 10'h000;
    localparam logic [7:0] SSR_BAUD_RST = 8'h00;
    localparam logic [1:0] SSR_RESP_OKAY = 2'h0;
    localparam logic [1:0] SSR_RESP_SLVERR = 2'h2;
    localparam logic [3:0] SSR_BITS_8 = 4'h8;
    localparam logic [3:0] SSR_BITS_9 = 4'h9;
    localparam logic [1:0] SSR_FIFO_DEPTH = 2'h2;
    localparam logic [1:0] SSR_LOW_SPEED_SHIFT = 2'h2;
    localparam int SSR_STATUS_COUNT_LSB = 3;

    // control register; first member is the top bit, serial_port_enable is bit 0
    typedef struct packed {
        logic global_interrupt_enable;
        logic peripheral_interrupt_enable;
        logic receive_interrupt_enable;
        logic address_detect_enable;
        logic high_baud_select;
        logic nine_bit_receive_enable;
        logic continuous_receive_enable;
        logic single_receive_enable;
        logic master_clock_select;
        logic serial_port_enable;
    } ssr_ctrl_s;

    typedef struct packed {
        logic [1:0] count;
        logic ninth_received_bit;
        logic overrun_error_flag;
        logic receive_flag;
    } ssr_status_s;
endpackage

//--- rtl/ssr_top.sv
// synchronous serial receiver with axi4-lite register slave
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module ssr_top import ssr_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic serial_data_pin_i,
    output logic serial_data_pin_o,
    output logic serial_data_pin_oe,
    output logic irq
);
    ssr_ctrl_s ctrl_q;
    logic [7:0] baud_q;
    logic [9:0] div_cnt_q;
    logic [3:0] bit_cnt_q;
    logic [8:0] shift_q;
    logic [8:0] fifo_q [2];
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic overrun_q;
    logic overrun_single_q;
    logic [1:0] sclk_sync_q;
    logic [1:0] sdat_sync_q;
    logic sclk_prev_q;
    logic aw_have_q;
    logic w_have_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;

    function automatic logic addr_known(input logic [3:0] a);
        return a == SSR_ADDR_CTRL || a == SSR_ADDR_STATUS || a == SSR_ADDR_DATA || a == SSR_ADDR_BAUD;
    endfunction

    wire logic en = ctrl_q.serial_port_enable;
    wire logic master = ctrl_q.master_clock_select;
    wire logic nine = ctrl_q.nine_bit_receive_enable;
    // overrun blocks reception but leaves the fifo readable
    wire logic rx_on = en && (ctrl_q.single_receive_enable || ctrl_q.continuous_receive_enable) && !overrun_q;
    wire logic [3:0] char_bits = nine ? SSR_BITS_9 : SSR_BITS_8;
    wire logic [9:0] div_lim = ctrl_q.high_baud_select ? {2'h0, baud_q}
        : ({2'h0, baud_q} << SSR_LOW_SPEED_SHIFT) | 10'h003;
    wire logic tick = (div_cnt_q == div_lim);
    wire logic m_fall = master && rx_on && tick && serial_clock_pin_o;
    wire logic s_fall = !master && rx_on && sclk_prev_q && !sclk_sync_q[1];
    wire logic sample = m_fall || s_fall;
    wire logic [8:0] shift_d = {sdat_sync_q[1], shift_q[8:1]};
    wire logic done = sample && (bit_cnt_q + 4'h1 == char_bits);
    wire logic [8:0] char_d = nine ? shift_d : {1'b0, shift_d[8:1]};
    wire logic full = (count_q == SSR_FIFO_DEPTH);
    wire logic push = done && !full;
    wire logic rd_hs = s_axi_arvalid && s_axi_arready;
    wire logic pop = rd_hs && s_axi_araddr == SSR_ADDR_DATA && count_q != 2'h0;
    wire logic wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    wire logic [8:0] head = fifo_q[rd_ptr_q];
    ssr_status_s status;
    assign status = '{count: count_q, ninth_received_bit: head[8],
        overrun_error_flag: overrun_q, receive_flag: count_q != 2'h0};

    // pins from other domain pass two flops
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_sync_q <= 2'h0;
            sdat_sync_q <= 2'h0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], serial_clock_pin_i};
            sdat_sync_q <= {sdat_sync_q[0], serial_data_pin_i};
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    // control register: hardware clear of single enable loses to a software write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= SSR_CTRL_RST;
            baud_q <= SSR_BAUD_RST;
        end else begin
            if (done)
                ctrl_q.single_receive_enable <= 1'b0;
            if (wr_go && aw_addr_q == SSR_ADDR_CTRL) begin
                if (w_strb_q[0])
                    ctrl_q[7:0] <= w_data_q[7:0];
                if (w_strb_q[1])
                    ctrl_q[SSR_CTRL_W-1:8] <= w_data_q[SSR_CTRL_W-1:8];
            end
            if (wr_go && aw_addr_q == SSR_ADDR_BAUD && w_strb_q[0])
                baud_q <= w_data_q[7:0];
        end
    end

    // master clock generator; idle low, rise is the leading edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_q <= 10'h000;
            serial_clock_pin_o <= 1'b0;
            serial_clock_pin_oe <= 1'b0;
        end else begin
            serial_clock_pin_oe <= en && master;
            if (!(master && rx_on)) begin
                div_cnt_q <= 10'h000;
                serial_clock_pin_o <= 1'b0;
            end else if (tick) begin
                div_cnt_q <= 10'h000;
                if (serial_clock_pin_o)
                    serial_clock_pin_o <= 1'b0;
                else if (!(done || (bit_cnt_q == 4'h0 && !ctrl_q.continuous_receive_enable
                        && !ctrl_q.single_receive_enable)))
                    serial_clock_pin_o <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 10'h001;
            end
        end
    end

    // data pin is input only in every receive mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else begin
            serial_data_pin_o <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end
    end

    // shift register and bit counter; a stopped receiver drops its partial character
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shift_q <= 9'h000;
            bit_cnt_q <= 4'h0;
        end else if (!rx_on) begin
            shift_q <= 9'h000;
            bit_cnt_q <= 4'h0;
        end else if (sample) begin
            shift_q <= shift_d;
            bit_cnt_q <= done ? 4'h0 : bit_cnt_q + 4'h1;
        end
    end

    // two-entry receive fifo
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_q[0] <= 9'h000;
            fifo_q[1] <= 9'h000;
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else if (!en) begin
            rd_ptr_q <= 1'b0;
            count_q <= 2'h0;
        end else begin
            if (push)
                fifo_q[rd_ptr_q ^ count_q[0]] <= char_d;
            if (pop)
                rd_ptr_q <= !rd_ptr_q;
            count_q <= count_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // overrun: port disable clear comes first, then set, then the data read or continuous enable clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overrun_q <= 1'b0;
            overrun_single_q <= 1'b0;
        end else if (!en) begin
            overrun_q <= 1'b0;
        end else if (done && full) begin
            overrun_q <= 1'b1;
            overrun_single_q <= !ctrl_q.continuous_receive_enable;
        end else if (overrun_q) begin
            if (overrun_single_q ? (rd_hs && s_axi_araddr == SSR_ADDR_DATA)
                    : !ctrl_q.continuous_receive_enable)
                overrun_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= status.receive_flag && ctrl_q.receive_interrupt_enable
                && ctrl_q.peripheral_interrupt_enable && ctrl_q.global_interrupt_enable;
    end

    // axi write channel: address and data taken in either order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SSR_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_known(aw_addr_q) ? SSR_RESP_OKAY : SSR_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // axi read channel; a data read pops the fifo
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= SSR_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_hs;
            if (rd_hs) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= addr_known(s_axi_araddr) ? SSR_RESP_OKAY : SSR_RESP_SLVERR;
                unique case (s_axi_araddr)
                    SSR_ADDR_CTRL: s_axi_rdata <= {22'h0, ctrl_q};
                    SSR_ADDR_STATUS: s_axi_rdata <= {27'h0, status};
                    SSR_ADDR_DATA: s_axi_rdata <= {24'h0, head[7:0]};
                    SSR_ADDR_BAUD: s_axi_rdata <= {24'h0, baud_q};
                    default: s_axi_rdata <= 32'h0;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // ssr_top

//--- sim/ssr_top_asserts.sv
// port-level checks of the synchronous serial receiver
`timescale 1ns/1ps
module ssr_top_asserts import ssr_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_data_pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    AST_DATA_OE_OFF: assert property (!serial_data_pin_oe)
        else $error("data pin driven by receiver");
    AST_SLAVE_CLK_QUIET: assert property (!serial_clock_pin_oe |-> !serial_clock_pin_o)
        else $error("clock output high while not driven");
    // taken items are registered first, so the response shows on the second edge after the take
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("no write response after take");
    AST_WRITE_CLOSE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not closed");
    AST_WRITE_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data after take");
    AST_READ_CLOSE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not closed");
    AST_READ_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    AST_BRESP_CODE: assert property (s_axi_bvalid |-> s_axi_bresp == SSR_RESP_OKAY || s_axi_bresp == SSR_RESP_SLVERR)
        else $error("bad write response code");
endmodule // ssr_top_asserts
bind ssr_top ssr_top_asserts ssr_top_asserts_inst (.clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .serial_clock_pin_o, .serial_clock_pin_oe, .serial_data_pin_oe);

//--- sim/ssr_peer.sv
// far-end serial peer: feeds a master receiver or clocks a slave one
`timescale 1ns/1ps
module ssr_peer (
    input wire logic m_sck,
    input wire logic [8:0] word,
    input wire logic [3:0] nbits,
    output logic s_sck,
    output logic dat
);
    int idx = 0;
    initial begin
        s_sck = 1'b0;
        dat = 1'b0;
    end
    always @(posedge m_sck) begin
        dat = word[idx];
        idx = (idx + 1 >= nbits) ? 0 : idx + 1;
    end
    // hold time spent, so the line stops showing the bit
    always @(negedge m_sck) begin
        #28;
        if (!m_sck) dat = ~dat;
    end
    task automatic send(input logic [8:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            dat = w[i];
            s_sck = 1'b1;
            #80;
            s_sck = 1'b0;
            #40;
            dat = ~dat;
            #40;
        end
    endtask
endmodule // ssr_peer

//--- sim/ssr_top_tb.sv
// self-checking bench of the synchronous serial receiver
`timescale 1ns/1ps
module ssr_top_tb import ssr_pkg::*;;
    logic clk = 0, rst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h3, nbits = 4'h8;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, peer_sck, peer_dat;
    logic serial_clock_pin_o, serial_clock_pin_oe, serial_data_pin_o, serial_data_pin_oe;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [8:0] word = 9'h0;
    int error_cnt = 0, n_checks = 0, falls = 0, hi_cnt = 0;
    wire logic serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : peer_sck;
    wire logic serial_data_pin_i = serial_data_pin_oe ? serial_data_pin_o : peer_dat;
    ssr_top ssr_top_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_pin_i,
        .serial_clock_pin_o, .serial_clock_pin_oe, .serial_data_pin_i, .serial_data_pin_o, .serial_data_pin_oe, .irq);
    ssr_peer ssr_peer_inst (.m_sck(serial_clock_pin_o & serial_clock_pin_oe), .word, .nbits, .s_sck(peer_sck),
        .dat(peer_dat));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(negedge serial_clock_pin_o) falls++;
    always @(posedge clk) if (serial_clock_pin_o === 1'b1) hi_cnt++;
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
        if (what == "timeout") end_of_test();
    endtask
    task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        s_axi_bready <= 1'b0;
        if (n >= 200) chk("timeout", 1, 0);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    endtask
    task automatic axr(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata;
        if (n >= 200) chk("timeout", 1, 0);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task automatic rdc(input string what, input logic [3:0] a, input logic [31:0] exp);
        axr(a, rd, SSR_RESP_OKAY);
        chk(what, exp, rd);
    endtask
    // polls status until one of the mask bits shows
    task automatic waitst(input logic [31:0] mask);
        int n = 0;
        do begin
            axr(SSR_ADDR_STATUS, rd, SSR_RESP_OKAY);
            n++;
        end while ((rd & mask) === 32'h0 && n < 300);
        if (n >= 300) chk("timeout", 1, 0);
    endtask
    function automatic logic [31:0] st(input logic [1:0] cnt, input logic ov, input logic n9);
        return {27'h0, cnt, n9, ov, |cnt};
    endfunction
    function automatic logic [31:0] mk(input logic m, input logic sr, input logic cr, input logic n9, input logic ie);
        ssr_ctrl_s c;
        c = SSR_CTRL_RST;
        c.serial_port_enable = 1'b1;
        c.master_clock_select = m;
        c.single_receive_enable = sr;
        c.continuous_receive_enable = cr;
        c.nine_bit_receive_enable = n9;
        c.high_baud_select = 1'b1;
        c.receive_interrupt_enable = ie;
        c.peripheral_interrupt_enable = ie;
        c.global_interrupt_enable = ie;
        return {22'h0, c};
    endfunction
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl_reset", SSR_ADDR_CTRL, {22'h0, SSR_CTRL_RST});
        rdc("baud_reset", SSR_ADDR_BAUD, {24'h0, SSR_BAUD_RST});
        rdc("status_reset", SSR_ADDR_STATUS, st(2'h0, 1'b0, 1'b0));
        axw(4'h2, 32'h1, SSR_RESP_SLVERR);
        axr(4'h2, rd, SSR_RESP_SLVERR);
        $display("test reset_map done");
        word = 9'h0a5;
        axw(SSR_ADDR_BAUD, 32'h3, SSR_RESP_OKAY);
        hi_cnt = 0;
        // the reset edge of the clock output counts as a fall
        falls = 0;
        axw(SSR_ADDR_CTRL, mk(1, 1, 0, 0, 1), SSR_RESP_OKAY);
        // the pin enable follows the register one edge later
        @(posedge clk);
        chk("clk_oe", 1, {31'h0, serial_clock_pin_oe});
        chk("data_oe", 0, {31'h0, serial_data_pin_oe});
        waitst(32'h1);
        repeat (40) @(posedge clk);
        chk("falls", 8, falls);
        chk("clock_high_cycles", 8 * 4, hi_cnt);
        chk("irq", 1, {31'h0, irq});
        rdc("ctrl_after", SSR_ADDR_CTRL, mk(1, 0, 0, 0, 1));
        rdc("status_one", SSR_ADDR_STATUS, st(2'h1, 1'b0, 1'b0));
        rdc("data", SSR_ADDR_DATA, 32'ha5);
        rdc("status_empty", SSR_ADDR_STATUS, st(2'h0, 1'b0, 1'b0));
        chk("irq_off", 0, {31'h0, irq});
        $display("test single_master done");
        ssr_peer_inst.idx = 0;
        word = 9'h03c;
        falls = 0;
        axw(SSR_ADDR_CTRL, mk(1, 0, 1, 0, 0), SSR_RESP_OKAY);
        waitst(32'h2);
        repeat (20) @(posedge clk);
        chk("clocks_run_on", 3 * 8, falls);
        rdc("status_overrun", SSR_ADDR_STATUS, st(2'h2, 1'b1, 1'b0));
        axw(SSR_ADDR_CTRL, mk(1, 0, 0, 0, 0), SSR_RESP_OKAY);
        rdc("overrun_cleared", SSR_ADDR_STATUS, st(2'h2, 1'b0, 1'b0));
        rdc("data_first", SSR_ADDR_DATA, 32'h3c);
        rdc("data_second", SSR_ADDR_DATA, 32'h3c);
        $display("test overrun done");
        ssr_peer_inst.idx = 0;
        word = 9'h1c3;
        nbits = 4'h9;
        falls = 0;
        hi_cnt = 0;
        // low speed range: high_baud_select (bit 5) cleared
        axw(SSR_ADDR_CTRL, mk(1, 1, 0, 1, 0) & ~32'h20, SSR_RESP_OKAY);
        waitst(32'h1);
        repeat (40) @(posedge clk);
        chk("falls_nine", 9, falls);
        chk("clock_high_slow", 9 * (4 * 3 + 4), hi_cnt);
        rdc("status_ninth", SSR_ADDR_STATUS, st(2'h1, 1'b0, 1'b1));
        rdc("data_nine", SSR_ADDR_DATA, 32'hc3);
        nbits = 4'h8;
        $display("test nine_bit done");
        ssr_peer_inst.idx = 0;
        word = 9'h066;
        falls = 0;
        axw(SSR_ADDR_CTRL, mk(1, 1, 1, 0, 0), SSR_RESP_OKAY);
        waitst(32'h1);
        rdc("ctrl_both", SSR_ADDR_CTRL, mk(1, 0, 1, 0, 0));
        axw(SSR_ADDR_CTRL, mk(1, 0, 0, 0, 0), SSR_RESP_OKAY);
        repeat (40) @(posedge clk);
        chk("clock_stopped", 1, {31'h0, falls < 16 && serial_clock_pin_o === 1'b0});
        rdc("partial_dropped", SSR_ADDR_STATUS, st(2'h1, 1'b0, 1'b0));
        rdc("data_both", SSR_ADDR_DATA, 32'h66);
        $display("test abort done");
        // single enable would stop after one character, so the slave runs continuous
        axw(SSR_ADDR_CTRL, mk(0, 0, 1, 0, 0), SSR_RESP_OKAY);
        @(posedge clk);
        chk("slave_clk_oe", 0, {31'h0, serial_clock_pin_oe});
        ssr_peer_inst.send(9'h05a, 8);
        ssr_peer_inst.send(9'h05a, 8);
        repeat (10) @(posedge clk);
        rdc("slave_status", SSR_ADDR_STATUS, st(2'h2, 1'b0, 1'b0));
        rdc("slave_data", SSR_ADDR_DATA, 32'h5a);
        // single mode overrun: the third character meets a full fifo
        axw(SSR_ADDR_CTRL, mk(0, 1, 0, 0, 0), SSR_RESP_OKAY);
        ssr_peer_inst.send(9'h0c3, 8);
        axw(SSR_ADDR_CTRL, mk(0, 1, 0, 0, 0), SSR_RESP_OKAY);
        ssr_peer_inst.send(9'h0ff, 8);
        repeat (10) @(posedge clk);
        rdc("single_overrun", SSR_ADDR_STATUS, st(2'h2, 1'b1, 1'b0));
        rdc("data_oldest", SSR_ADDR_DATA, 32'h5a);
        rdc("single_overrun_cleared", SSR_ADDR_STATUS, st(2'h1, 1'b0, 1'b0));
        rdc("data_kept", SSR_ADDR_DATA, 32'hc3);
        axw(SSR_ADDR_CTRL, 32'h0, SSR_RESP_OKAY);
        rdc("port_reset", SSR_ADDR_STATUS, st(2'h0, 1'b0, 1'b0));
        $display("test slave done");
        end_of_test();
    end
endmodule // ssr_top_tb
